// [rtl/pcsm_config_status_mirror.v]
`include "pcsm_regs.vh"
`default_nettype none

// Configuration status mirror toward the user application.
// Every output is taken from a flop one user clock after its source.
module pcsm_config_status_mirror #(
  parameter NUM_PF = `PCSM_NUM_PF,
  parameter NUM_VF = `PCSM_NUM_VF,
  parameter CTRL_W = `PCSM_TPH_CTRL_W,
  parameter SUB_W = `PCSM_DPA_SUB_W
) (
  // Clock and reset
  input wire clk,
  input wire rst,

  // Operating mode, high for Root Port, low for Endpoint
  input wire root_port_mode,

  // Completion boundary sources
  input wire [NUM_PF-1:0] pf_link_ctrl_rcb,
  input wire rp_link_ctrl_rcb,

  // Allocation control register writes, one strobe per function
  input wire [NUM_PF-1:0] dpa_ctrl_wr,
  input wire [NUM_PF*SUB_W-1:0] dpa_ctrl_wr_substate,

  // Device Control 2 flush/fill enable field
  input wire [`PCSM_OBFF_W-1:0] dev_ctrl2_obff,

  // Link layer event pulses
  input wire link_bw_mgmt_event,
  input wire link_auto_bw_event,
  input wire link_eq_req_event,

  // Interrupt enables from Link Control and Link Control 3
  input wire bw_mgmt_int_en,
  input wire auto_bw_int_en,
  input wire eq_int_en,

  // Status clears from configuration writes of one
  input wire bw_mgmt_status_clr,
  input wire auto_bw_status_clr,
  input wire eq_req_status_clr,

  // Requester control words, function 0 in the low word
  input wire [NUM_PF*CTRL_W-1:0] pf_tph_ctrl,
  input wire [NUM_VF*CTRL_W-1:0] vf_tph_ctrl,

  // Completion boundary status
  output wire [NUM_PF-1:0] rcb_status,

  // Allocation substate change pulses and current substates
  output wire [NUM_PF-1:0] dpa_substate_change,
  output wire [NUM_PF*SUB_W-1:0] dpa_substate,

  // Flush/fill enable mirror and its decode
  output wire [`PCSM_OBFF_W-1:0] obff_enable,
  output wire obff_wake_mode,

  // Link status change event and sticky status bits
  output wire link_status_change_event,
  output wire bw_mgmt_status,
  output wire auto_bw_status,
  output wire eq_req_status,

  // Processing hint mirrors for physical functions
  output wire [NUM_PF-1:0] hint_requester_enable_pf,
  output wire [NUM_PF*`PCSM_TPH_ST_MODE_W-1:0] steering_tag_mode_pf,

  // Processing hint mirrors for virtual functions
  output wire [NUM_VF-1:0] hint_requester_enable_vf,
  output wire [NUM_VF*`PCSM_TPH_ST_MODE_W-1:0] steering_tag_mode_vf
);

  // ------------------------------------------------------------
  // Completion boundary status
  // ------------------------------------------------------------

  reg [NUM_PF-1:0] rcb_q; // Registered boundary bits
  reg [NUM_PF-1:0] rcb_d; // Next boundary bits

  // Pick the source by mode; reserved bits read as zero
  always @* begin
    rcb_d = pf_link_ctrl_rcb;
    if (root_port_mode) begin
      // Only the port's own Link Control exists here
      rcb_d = {NUM_PF{`PCSM_RCB_RESERVED}};
      rcb_d[0] = rp_link_ctrl_rcb;
    end
  end

  // Boundary bits pass as they are: 0 is 64 bytes, 1 is 128 bytes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rcb_q <= {NUM_PF{`PCSM_RCB_64B}};
    end else begin
      rcb_q <= rcb_d;
    end
  end

  assign rcb_status = rcb_q;

  // ------------------------------------------------------------
  // Allocation substate change, one tracker per function
  // ------------------------------------------------------------

  wire endpoint_mode; // Inverse of the mode input
  assign endpoint_mode = ~root_port_mode;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PF; gp = gp + 1) begin : g_pf
      // Tracker index equals the function number, so pulse bit matches
      pcsm_dpa_track #(
        .SUB_W(SUB_W)
      ) u_dpa (
        .clk(clk),
        .rst(rst),
        .cfg_wr(dpa_ctrl_wr[gp]),
        .cfg_wr_substate(dpa_ctrl_wr_substate[gp*SUB_W +: SUB_W]),
        .endpoint_mode(endpoint_mode),
        .substate(dpa_substate[gp*SUB_W +: SUB_W]),
        .change_pulse(dpa_substate_change[gp])
      );

      // Physical function hint fields
      pcsm_tph_mirror #(
        .CTRL_W(CTRL_W)
      ) u_tph_pf (
        .clk(clk),
        .rst(rst),
        .ctrl_word(pf_tph_ctrl[gp*CTRL_W +: CTRL_W]),
        .req_enable(hint_requester_enable_pf[gp]),
        .st_mode(steering_tag_mode_pf[gp*`PCSM_TPH_ST_MODE_W +:
          `PCSM_TPH_ST_MODE_W])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Virtual function hint fields
  // ------------------------------------------------------------

  genvar gv;
  generate
    for (gv = 0; gv < NUM_VF; gv = gv + 1) begin : g_vf
      // Function 0 lands in bits 2:0, each next one three bits up
      pcsm_tph_mirror #(
        .CTRL_W(CTRL_W)
      ) u_tph_vf (
        .clk(clk),
        .rst(rst),
        .ctrl_word(vf_tph_ctrl[gv*CTRL_W +: CTRL_W]),
        .req_enable(hint_requester_enable_vf[gv]),
        .st_mode(steering_tag_mode_vf[gv*`PCSM_TPH_ST_MODE_W +:
          `PCSM_TPH_ST_MODE_W])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Buffer flush/fill enable
  // ------------------------------------------------------------

  reg [`PCSM_OBFF_W-1:0] obff_q; // Mirrored field
  reg wake_q; // Wire signalling selected

  // All four codes are meaningful, so the field passes unchanged
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      obff_q <= `PCSM_OBFF_OFF;
      wake_q <= 1'b0;
    end else begin
      obff_q <= dev_ctrl2_obff;
      // Decode kept beside the field so users need not compare codes
      wake_q <= (dev_ctrl2_obff == `PCSM_OBFF_WAKE);
    end
  end

  assign obff_enable = obff_q;
  assign obff_wake_mode = wake_q;

  // ------------------------------------------------------------
  // Link status sticky bits
  // ------------------------------------------------------------

  reg bw_st_q; // Local bandwidth change status
  reg bw_st_d;
  reg au_st_q; // Autonomous bandwidth change status
  reg au_st_d;
  reg eq_st_q; // Equalization request status
  reg eq_st_d;

  wire bw_set; // Local change seen in Root Port mode
  wire au_set; // Remote autonomous change seen
  wire eq_set; // Remote equalization request seen

  // These status bits only exist for the Root Port
  assign bw_set = link_bw_mgmt_event && root_port_mode;
  assign au_set = link_auto_bw_event && root_port_mode;
  assign eq_set = link_eq_req_event && root_port_mode;

  // Set wins over a clear in the same cycle so no event is lost
  always @* begin
    bw_st_d = bw_st_q;
    au_st_d = au_st_q;
    eq_st_d = eq_st_q;
    if (bw_mgmt_status_clr) begin
      bw_st_d = 1'b0;
    end
    if (bw_set) begin
      bw_st_d = 1'b1;
    end
    if (auto_bw_status_clr) begin
      au_st_d = 1'b0;
    end
    if (au_set) begin
      au_st_d = 1'b1;
    end
    if (eq_req_status_clr) begin
      eq_st_d = 1'b0;
    end
    if (eq_set) begin
      eq_st_d = 1'b1;
    end
    // Leaving Root Port mode drops status that no longer applies
    if (!root_port_mode) begin
      bw_st_d = 1'b0;
      au_st_d = 1'b0;
      eq_st_d = 1'b0;
    end
  end

  // Status flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bw_st_q <= 1'b0;
      au_st_q <= 1'b0;
      eq_st_q <= 1'b0;
    end else begin
      bw_st_q <= bw_st_d;
      au_st_q <= au_st_d;
      eq_st_q <= eq_st_d;
    end
  end

  assign bw_mgmt_status = bw_st_q;
  assign auto_bw_status = au_st_q;
  assign eq_req_status = eq_st_q;

  // ------------------------------------------------------------
  // Link status change event
  // ------------------------------------------------------------

  reg bw_en_q; // Enables as seen last cycle
  reg au_en_q;
  reg eq_en_q;
  reg evt_q; // Registered event pulse
  reg evt_d;

  // Enable history, for catching status already pending
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bw_en_q <= 1'b0;
      au_en_q <= 1'b0;
      eq_en_q <= 1'b0;
    end else begin
      bw_en_q <= bw_mgmt_int_en;
      au_en_q <= auto_bw_int_en;
      eq_en_q <= eq_int_en;
    end
  end

  // Fresh enabled event, or an enable turned on over pending status.
  // The second term stops a change that raced the enable write from
  // being silently absorbed.
  always @* begin
    evt_d = 1'b0;
    if (bw_set && bw_mgmt_int_en) begin
      evt_d = 1'b1;
    end
    if (au_set && auto_bw_int_en) begin
      evt_d = 1'b1;
    end
    if (eq_set && eq_int_en) begin
      evt_d = 1'b1;
    end
    if (bw_st_q && bw_mgmt_int_en && !bw_en_q) begin
      evt_d = 1'b1;
    end
    if (au_st_q && auto_bw_int_en && !au_en_q) begin
      evt_d = 1'b1;
    end
    if (eq_st_q && eq_int_en && !eq_en_q) begin
      evt_d = 1'b1;
    end
    // Endpoint never reports link status changes here
    if (!root_port_mode) begin
      evt_d = 1'b0;
    end
  end

  // One-cycle pulse per qualifying cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      evt_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
    end
  end

  assign link_status_change_event = evt_q;

endmodule
`default_nettype wire

// [rtl/pcsm_regs.vh]
// How it works
// - Endpoint: completion boundary bit per physical function
// - Root Port: bit 0 from port, bit 1 zero
// - Boundary bit 0 means 64, 1 means 128
// - Endpoint: pulse when allocation write changes state
// - Pulse index equals affected physical function number
// - Root Port: substate change pulses stay low
// - Flush/fill enable follows Device Control 2 field
// - Encoding: off, message A, message B, wake
// - Root Port: local bandwidth change, if enabled
// - Root Port: autonomous remote bandwidth change, if enabled
// - Root Port: equalization request status set, if enabled
// - Endpoint: link status change stays low
// - Requester enable bit 8 per physical function
// - Steering mode: function 0 low, function 1 high
// - Requester enable bit 8 per virtual function
// - Steering mode three bits per virtual function
`ifndef PCSM_REGS_VH
`define PCSM_REGS_VH

// Function counts
`define PCSM_NUM_PF 2
`define PCSM_NUM_VF 6

// Completion boundary encoding
`define PCSM_RCB_64B 1'b0
`define PCSM_RCB_128B 1'b1
`define PCSM_RCB_RESERVED 1'b0

// Buffer flush/fill enable encoding
`define PCSM_OBFF_W 2
`define PCSM_OBFF_OFF 2'h0
`define PCSM_OBFF_MSG_A 2'h1
`define PCSM_OBFF_MSG_B 2'h2
`define PCSM_OBFF_WAKE 2'h3

// Requester control word layout
`define PCSM_TPH_CTRL_W 32
`define PCSM_TPH_REQ_EN_BIT 8
`define PCSM_TPH_ST_MODE_LSB 0
`define PCSM_TPH_ST_MODE_W 3

// Power allocation control substate field
`define PCSM_DPA_SUB_W 5
`define PCSM_DPA_SUB_RST 5'h00

// Latency from source change to output, in user clocks
`define PCSM_MIRROR_LATENCY 1

`endif

// [rtl/pcsm_dpa_track.v]
`include "pcsm_regs.vh"
`default_nettype none

// Holds one function's allocation substate and flags real changes
module pcsm_dpa_track #(
  parameter SUB_W = `PCSM_DPA_SUB_W
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Configuration write into the allocation control register
  input wire cfg_wr,
  input wire [SUB_W-1:0] cfg_wr_substate,
  // High while the core is an Endpoint
  input wire endpoint_mode,
  // Current substate and change pulse
  output wire [SUB_W-1:0] substate,
  output wire change_pulse
);

  reg [SUB_W-1:0] sub_q; // Stored substate
  reg pulse_q; // One-cycle change flag
  wire differs; // Write carries a new value

  assign differs = cfg_wr && (cfg_wr_substate != sub_q);

  // Store the written substate, pulse only if it moved
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sub_q <= `PCSM_DPA_SUB_RST;
      pulse_q <= 1'b0;
    end else begin
      if (cfg_wr) begin
        sub_q <= cfg_wr_substate;
      end
      // Rewriting the same state is not an event
      pulse_q <= differs && endpoint_mode;
    end
  end

  assign substate = sub_q;
  assign change_pulse = pulse_q;

endmodule
`default_nettype wire

// [rtl/pcsm_tph_mirror.v]
`include "pcsm_regs.vh"
`default_nettype none

// Registers the requester enable and mode fields of one function
module pcsm_tph_mirror #(
  parameter CTRL_W = `PCSM_TPH_CTRL_W
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Requester control word of this function
  input wire [CTRL_W-1:0] ctrl_word,
  // Mirrored fields
  output wire req_enable,
  output wire [`PCSM_TPH_ST_MODE_W-1:0] st_mode
);

  reg en_q; // Mirrored enable bit
  reg [`PCSM_TPH_ST_MODE_W-1:0] mode_q; // Mirrored mode select

  // One flop stage keeps the fabric path short and the latency fixed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
      mode_q <= {`PCSM_TPH_ST_MODE_W{1'b0}};
    end else begin
      en_q <= ctrl_word[`PCSM_TPH_REQ_EN_BIT];
      mode_q <= ctrl_word[`PCSM_TPH_ST_MODE_LSB +: `PCSM_TPH_ST_MODE_W];
    end
  end

  assign req_enable = en_q;
  assign st_mode = mode_q;

endmodule
`default_nettype wire

// [tb/pcsm_mirror_props.sv]
`default_nettype none
// Ties mirrors and pulses to their sources one user clock earlier, except dpa_substate, PF 0 steering mode and VF 0 to 4 hints
module pcsm_mirror_props #(
  parameter NUM_PF = 2,
  parameter NUM_VF = 6,
  parameter CTRL_W = 32,
  parameter SUB_W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Sources
  input wire logic root_port_mode,
  input wire logic [NUM_PF-1:0] pf_link_ctrl_rcb,
  input wire logic rp_link_ctrl_rcb,
  input wire logic [NUM_PF-1:0] dpa_ctrl_wr,
  input wire logic [NUM_PF*SUB_W-1:0] dpa_ctrl_wr_substate,
  input wire logic [1:0] dev_ctrl2_obff,
  input wire logic link_auto_bw_event,
  input wire logic auto_bw_int_en,
  input wire logic [NUM_PF*CTRL_W-1:0] pf_tph_ctrl,
  input wire logic [NUM_VF*CTRL_W-1:0] vf_tph_ctrl,
  // Mirrors and pulses
  input wire logic [NUM_PF-1:0] rcb_status,
  input wire logic [NUM_PF-1:0] dpa_substate_change,
  input wire logic [NUM_PF*SUB_W-1:0] dpa_substate,
  input wire logic [1:0] obff_enable,
  input wire logic obff_wake_mode,
  input wire logic link_status_change_event,
  input wire logic [NUM_PF-1:0] hint_requester_enable_pf,
  input wire logic [NUM_PF*3-1:0] steering_tag_mode_pf,
  input wire logic [NUM_VF-1:0] hint_requester_enable_vf,
  input wire logic [NUM_VF*3-1:0] steering_tag_mode_vf
);
  timeunit 1ns;
  timeprecision 1ps;
  // One domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Guard on past reset: flops still hold their reset value there
  a_rcb_ep_bits: assert property (!$past(rst)
    && !$past(root_port_mode) |-> rcb_status == $past(pf_link_ctrl_rcb))
    else $error("rcb endpoint");
  a_rcb_rp_bits: assert property (!$past(rst)
    && $past(root_port_mode) |-> rcb_status == {1'b0, $past(rp_link_ctrl_rcb)})
    else $error("rcb rp");
  a_dpa_pulse_cause: assert property (!root_port_mode &&
    dpa_ctrl_wr[0] &&
    dpa_ctrl_wr_substate[SUB_W-1:0] != dpa_substate[SUB_W-1:0]
    |=> dpa_substate_change[0]) else $error("dpa pulse missing");
  a_dpa_pulse_index: assert property (dpa_substate_change[1]
    |-> $past(dpa_ctrl_wr[1]) && !$past(root_port_mode))
    else $error("dpa pulse without its write");
  a_obff_field: assert property (!$past(rst) |-> obff_enable ==
    $past(dev_ctrl2_obff) && obff_wake_mode == ($past(dev_ctrl2_obff) == 2'h3))
    else $error("obff mirror");
  a_link_auto_evt: assert property (root_port_mode && auto_bw_int_en &&
    link_auto_bw_event |=> link_status_change_event) else $error("link evt");
  a_link_ep_quiet: assert property ($past(!root_port_mode)
    |-> !link_status_change_event) else $error("link event in endpoint");
  a_hint_pf_fields: assert property (!$past(rst) |->
    hint_requester_enable_pf == {$past(pf_tph_ctrl[40]), $past(pf_tph_ctrl[8])}
    && steering_tag_mode_pf[5:3] == $past(pf_tph_ctrl[34:32]))
    else $error("pf hint mirror");
  a_hint_vf_top: assert property (!$past(rst) |->
    hint_requester_enable_vf[5] == $past(vf_tph_ctrl[168]) &&
    steering_tag_mode_vf[17:15] == $past(vf_tph_ctrl[162:160]))
    else $error("vf hint mirror");
  // Main scenarios
  c_link_evt: cover property (link_status_change_event);
  c_dpa_pf1: cover property (dpa_substate_change[1]);
  c_dpa_b2b: cover property (dpa_substate_change[0] [*2]);
endmodule

bind pcsm_config_status_mirror pcsm_mirror_props #(.NUM_PF(NUM_PF),
  .NUM_VF(NUM_VF), .CTRL_W(CTRL_W), .SUB_W(SUB_W)) u_props (
  .clk(clk), .rst(rst), .root_port_mode(root_port_mode),
  .pf_link_ctrl_rcb(pf_link_ctrl_rcb), .rp_link_ctrl_rcb(rp_link_ctrl_rcb),
  .dpa_ctrl_wr(dpa_ctrl_wr), .dpa_ctrl_wr_substate(dpa_ctrl_wr_substate),
  .dev_ctrl2_obff(dev_ctrl2_obff), .link_auto_bw_event(link_auto_bw_event),
  .auto_bw_int_en(auto_bw_int_en), .pf_tph_ctrl(pf_tph_ctrl),
  .vf_tph_ctrl(vf_tph_ctrl), .rcb_status(rcb_status),
  .dpa_substate_change(dpa_substate_change), .dpa_substate(dpa_substate),
  .obff_enable(obff_enable), .obff_wake_mode(obff_wake_mode),
  .link_status_change_event(link_status_change_event),
  .hint_requester_enable_pf(hint_requester_enable_pf),
  .steering_tag_mode_pf(steering_tag_mode_pf),
  .hint_requester_enable_vf(hint_requester_enable_vf),
  .steering_tag_mode_vf(steering_tag_mode_vf));
`default_nettype wire

// [tb/pcsm_user_model.sv]
`default_nettype none
// Fabric-side consumer: counts every cycle an event line is high,
// so a pulse wider than one cycle shows up as an extra count
module pcsm_user_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Event lines from the mirror
  input wire logic link_status_change_event,
  input wire logic [1:0] dpa_substate_change,
  // High-cycle counts
  output var int link_events,
  output var int dpa0_events,
  output var int dpa1_events
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sample on the user clock like real fabric logic
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      link_events <= 0;
      dpa0_events <= 0;
      dpa1_events <= 0;
    end else begin
      link_events <= link_events + int'(link_status_change_event);
      dpa0_events <= dpa0_events + int'(dpa_substate_change[0]);
      dpa1_events <= dpa1_events + int'(dpa_substate_change[1]);
    end
  end
endmodule
`default_nettype wire

// [tb/pcsm_config_status_mirror_tb.sv]
`include "pcsm_regs.vh"
`default_nettype none
module pcsm_config_status_mirror_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Stimulus, all zero until reset is gone
  logic clk = 1'b0, rst = 1'b1, root_port_mode = 1'b0;
  logic rp_link_ctrl_rcb = 1'b0;
  logic [1:0] pf_link_ctrl_rcb = 2'h0, dpa_ctrl_wr = 2'h0;
  logic [1:0] dev_ctrl2_obff = 2'h0;
  logic [9:0] dpa_ctrl_wr_substate = 10'h000;
  logic [2:0] evt = 3'h0, int_en = 3'h0, clr = 3'h0;
  logic [63:0] pf_tph_ctrl = 64'h0;
  logic [191:0] vf_tph_ctrl = 192'h0;
  // Observed outputs
  wire logic [1:0] rcb_status, dpa_substate_change, obff_enable, hint_pf;
  wire logic [9:0] dpa_substate;
  wire logic obff_wake_mode, link_evt, bw_st, auto_st, eq_st;
  wire logic [5:0] mode_pf, hint_vf;
  wire logic [17:0] mode_vf;
  int errors = 0, n_tests = 0, link_events, dpa0_events, dpa1_events;

  pcsm_config_status_mirror dut (.clk(clk), .rst(rst),
    .root_port_mode(root_port_mode), .pf_link_ctrl_rcb(pf_link_ctrl_rcb),
    .rp_link_ctrl_rcb(rp_link_ctrl_rcb), .dpa_ctrl_wr(dpa_ctrl_wr),
    .dpa_ctrl_wr_substate(dpa_ctrl_wr_substate),
    .dev_ctrl2_obff(dev_ctrl2_obff), .link_bw_mgmt_event(evt[0]),
    .link_auto_bw_event(evt[1]), .link_eq_req_event(evt[2]),
    .bw_mgmt_int_en(int_en[0]), .auto_bw_int_en(int_en[1]),
    .eq_int_en(int_en[2]), .bw_mgmt_status_clr(clr[0]),
    .auto_bw_status_clr(clr[1]), .eq_req_status_clr(clr[2]),
    .pf_tph_ctrl(pf_tph_ctrl), .vf_tph_ctrl(vf_tph_ctrl),
    .rcb_status(rcb_status), .dpa_substate_change(dpa_substate_change),
    .dpa_substate(dpa_substate), .obff_enable(obff_enable),
    .obff_wake_mode(obff_wake_mode), .link_status_change_event(link_evt),
    .bw_mgmt_status(bw_st), .auto_bw_status(auto_st), .eq_req_status(eq_st),
    .hint_requester_enable_pf(hint_pf), .steering_tag_mode_pf(mode_pf),
    .hint_requester_enable_vf(hint_vf), .steering_tag_mode_vf(mode_vf));

  pcsm_user_model u_user (.clk(clk), .rst(rst),
    .link_status_change_event(link_evt),
    .dpa_substate_change(dpa_substate_change),
    .link_events(link_events), .dpa0_events(dpa0_events),
    .dpa1_events(dpa1_events));

  // 100 MHz user clock
  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Land one past the edge so registered outputs have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Both modes, every boundary and flush/fill code
  task automatic t_mirror();
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) begin
        root_port_mode <= i[2];
        pf_link_ctrl_rcb <= i[1:0];
        rp_link_ctrl_rcb <= ~i[0];
        dev_ctrl2_obff <= i[1:0];
      end
      step(1);
      r = i[2] ? {1'b0, ~i[0]} : i[1:0];
      chk("rcb", r, rcb_status);
      chk("obff", i[1:0], obff_enable);
      chk("wake", i[1:0] == `PCSM_OBFF_WAKE, obff_wake_mode);
    end
  endtask

  // Two opposite patterns; filler bits set to expose wrong field picks
  task automatic t_hint();
    logic [191:0] w;
    logic [17:0] m;
    logic [5:0] e;
    for (int k = 0; k < 2; k++) begin
      for (int n = 0; n < 6; n++) begin
        e[n] = n[0] ^ k[0];
        m[n*3 +: 3] = k ? 3'(7 - n) : 3'(n + 1);
        w[n*32 +: 32] = {23'h7fffff ^ 23'(k), e[n], 5'h1f, m[n*3 +: 3]};
      end
      @(posedge clk) begin
        vf_tph_ctrl <= w;
        pf_tph_ctrl <= w[63:0];
      end
      step(1);
      chk("pf enable", e[1:0], hint_pf);
      chk("pf mode", m[5:0], mode_pf);
      chk("vf enable", e, hint_vf);
      chk("vf mode", m, mode_vf);
    end
  endtask

  task automatic t_dpa();
    int c0, c1;
    @(posedge clk) root_port_mode <= 1'b0;
    c0 = dpa0_events;
    c1 = dpa1_events;
    // New value on function 1 only
    @(posedge clk) begin
      dpa_ctrl_wr <= 2'h2;
      dpa_ctrl_wr_substate <= 10'h060;
    end
    // Same value again, then two differing writes back to back on function 0
    @(posedge clk) dpa_ctrl_wr <= 2'h2;
    @(posedge clk) begin
      dpa_ctrl_wr <= 2'h1;
      dpa_ctrl_wr_substate <= 10'h064;
    end
    @(posedge clk) dpa_ctrl_wr_substate <= 10'h065;
    @(posedge clk) dpa_ctrl_wr <= 2'h0;
    step(2);
    chk("dpa pf1 pulses", c1 + 1, dpa1_events);
    chk("dpa pf0 pulses", c0 + 2, dpa0_events);
    chk("dpa stored", 10'h065, dpa_substate);
    // Root Port: stored value moves, no pulse
    @(posedge clk) root_port_mode <= 1'b1;
    @(posedge clk) begin
      dpa_ctrl_wr <= 2'h3;
      dpa_ctrl_wr_substate <= 10'h129;
    end
    @(posedge clk) dpa_ctrl_wr <= 2'h0;
    step(2);
    chk("dpa rp pulses", c0 + c1 + 3, dpa0_events + dpa1_events);
    chk("dpa rp stored", 10'h129, dpa_substate);
  endtask

  task automatic pulse3(input logic [2:0] ev, c);
    @(posedge clk) begin evt <= ev; clr <= c; end
    @(posedge clk) begin evt <= 3'h0; clr <= 3'h0; end
  endtask

  // Each cause alone, then masked, then in Endpoint mode
  task automatic t_link();
    int l;
    @(posedge clk) begin root_port_mode <= 1'b1; int_en <= 3'h7; end
    for (int k = 0; k < 3; k++) begin
      l = link_events;
      pulse3(3'h1 << k, 3'h0);
      step(2);
      chk("link event", l + 1, link_events);
      chk("link status", 3'h1 << k, {eq_st, auto_st, bw_st});
      pulse3(3'h0, 3'h7);
      step(1);
      chk("link cleared", 3'h0, {eq_st, auto_st, bw_st});
    end
    l = link_events;
    @(posedge clk) int_en <= 3'h0;
    pulse3(3'h7, 3'h0);
    // Clear before re-enabling: a pending status would pulse on enable
    pulse3(3'h0, 3'h7);
    @(posedge clk) begin root_port_mode <= 1'b0; int_en <= 3'h7; end
    pulse3(3'h7, 3'h0);
    step(2);
    chk("link masked", l, link_events);
    chk("link ep status", 3'h0, {eq_st, auto_st, bw_st});
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    step(2);
    t_mirror();
    t_hint();
    t_dpa();
    t_link();
    report_and_stop();
  end

  // Run needs well under 200 cycles
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
